/* rtl/ldo_channel_control_regs.sv */
/*
  control register bank and state logic for one low-noise regulator
  channel. assumes an avalon-mm master, a sequencer on the same clock
  issuing one-cycle timeslot strobes, and asynchronous fault and
  hardware control/enable pins.
*/
// How it works
// - error action: ignore, shut regulator, reset device
// - undervoltage always sets interrupt status
// - hardware control source selects input 1, 2, either
// - hardware voltage choice picks on or sleep voltage
// - hardware mode: low power, off, follow on-mode
// - disabled output discharged unless float bit set
// - on slot 1..5 enables in startup timeslot
// - on slot 110/111 follows hardware enable 1/2
// - on-state mode bit selects low power
// - voltage 1.00V plus 50mV steps to 0Ch
// - above 0Ch 100mV steps from 1.70V
// - sleep codes 000/110/111 transition slots 5/3/1
// - sleep codes 001..101 disable in slots 5..1
// - hardware-enabled: codes 001..101 choose sleep slot
// - sleep mode bit selects low power, resets 1
// - sleep voltage uses same encoding
`timescale 1ns/1ns
module ldo_channel_control_regs (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [ldo_regs_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [ldo_regs_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [ldo_regs_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_undervoltage,
  input wire logic i_hw_control1,
  input wire logic i_hw_control2,
  input wire logic i_hw_enable1,
  input wire logic i_hw_enable2,
  input wire logic i_seq_strobe,
  input wire logic [2:0] i_seq_slot,
  input wire logic i_seq_to_sleep,
  output logic o_reg_enable,
  output logic o_reg_low_power,
  output logic [4:0] o_reg_voltage,
  output logic [11:0] o_target_mv,
  output logic o_output_discharge,
  output logic o_switch_mode,
  output logic o_device_reset,
  output logic o_irq
);
  import ldo_regs_pkg::*;

  // ==========================================================
  // pin synchronisers
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, clean_q;
  assign pin_raw = {i_hw_enable2, i_hw_enable1, i_hw_control2, i_hw_control1, i_undervoltage};

  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          clean_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            clean_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  wire uv_next = (s2_q[0] == s3_q[0]) ? s3_q[0] : clean_q[0];
  wire uv_rise = uv_next && !clean_q[0];
  wire hwc1 = clean_q[1];
  wire hwc2 = clean_q[2];
  wire hwe1 = clean_q[3];
  wire hwe2 = clean_q[4];

  // ==========================================================
  // registers and bus decode
  logic [15:0] fault_hwc_q, on_cfg_q, sleep_cfg_q, irq_status_q, irq_enable_q;
  logic wait_q;
  wire [15:0] word_idx = i_avs_address[17:2];
  wire hit_fault = (word_idx == IDX_FAULT_HWC);
  wire hit_on = (word_idx == IDX_ON_STATE);
  wire hit_sleep = (word_idx == IDX_SLEEP_STATE);
  wire hit_status = (word_idx == IDX_IRQ_STATUS);
  wire hit_enable = (word_idx == IDX_IRQ_ENABLE);
  wire wr_go = i_avs_write && !wait_q;
  wire req_new = (i_avs_read || i_avs_write) && wait_q;
  wire [15:0] lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [15:0] wdata = i_avs_writedata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] lanes,
                                         input logic [15:0] data, input logic [15:0] wmask);
    merge = ((old & ~lanes) | (data & lanes)) & wmask;
  endfunction : merge

  wire [15:0] rd_word = hit_fault ? fault_hwc_q :
                        hit_on ? on_cfg_q :
                        hit_sleep ? sleep_cfg_q :
                        hit_status ? irq_status_q :
                        hit_enable ? irq_enable_q : 16'h0000;

  // ==========================================================
  // field views
  wire [1:0] uv_action = fault_hwc_q[ACT_LO +: 2];
  wire [1:0] hw_control_source = fault_hwc_q[SRC_LO +: 2];
  wire hw_control_voltage_choice = fault_hwc_q[HWC_VSEL_BIT];
  wire [1:0] hw_control_mode = fault_hwc_q[HWM_LO +: 2];
  wire output_float_on_disable = fault_hwc_q[FLT_BIT];
  wire switch_mode_select = fault_hwc_q[SWI_BIT];
  wire [2:0] on_state_timeslot = on_cfg_q[SLOT_LO +: 3];
  wire on_state_low_power = on_cfg_q[MODE_BIT];
  wire [4:0] on_state_voltage = on_cfg_q[VOLT_LO +: 5];
  wire [2:0] sleep_state_timeslot = sleep_cfg_q[SLOT_LO +: 3];
  wire sleep_state_low_power = sleep_cfg_q[MODE_BIT];
  wire [4:0] sleep_state_voltage = sleep_cfg_q[VOLT_LO +: 5];

  // ==========================================================
  // sequencing decode
  function automatic logic [2:0] sleep_slot_of(input logic [2:0] code);
    unique case (code)
      3'h0: sleep_slot_of = 3'h5;
      3'h6: sleep_slot_of = 3'h3;
      3'h7: sleep_slot_of = 3'h1;
      default: sleep_slot_of = 3'h6 - code;
    endcase
  endfunction : sleep_slot_of

  reg_state_t state_q, state_d;
  wire on_hw = (on_state_timeslot[2:1] == 2'b11);
  wire hwe_sel = on_state_timeslot[0] ? hwe2 : hwe1;
  wire startup_hit = i_seq_strobe && !i_seq_to_sleep && !on_hw &&
                     (on_state_timeslot != SLOT_NONE) && (on_state_timeslot == i_seq_slot);
  wire sleep_hit = i_seq_strobe && i_seq_to_sleep &&
                   (i_seq_slot == sleep_slot_of(sleep_state_timeslot));
  wire sleep_is_disable = (sleep_state_timeslot != SLOT_NONE) &&
                          (sleep_state_timeslot <= SLOT_LAST);
  wire sleep_disable = sleep_hit && sleep_is_disable && !on_hw;
  wire uv_shut = uv_rise && (uv_action == ACT_SHUTDOWN);
  wire uv_reset = uv_rise && (uv_action == ACT_DEV_RESET);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (startup_hit || (on_hw && hwe_sel)) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (on_hw && !hwe_sel) begin
          state_d = ST_OFF;
        end else if (sleep_disable) begin
          state_d = ST_OFF;
        end else if (sleep_hit) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (on_hw && !hwe_sel) begin
          state_d = ST_OFF;
        end else if (startup_hit) begin
          state_d = ST_ON;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (uv_shut) begin
      state_d = ST_OFF;
    end
  end

  // ==========================================================
  // output control
  wire hwc_active = ((hw_control_source == SRC_HWC1) && hwc1) ||
                    ((hw_control_source == SRC_HWC2) && hwc2) ||
                    ((hw_control_source == SRC_EITHER) && (hwc1 || hwc2));
  wire enable_d = (state_d != ST_OFF) && !(hwc_active && (hw_control_mode == HWM_OFF));
  wire low_power_d = hwc_active ?
                     ((hw_control_mode == HWM_FOLLOW_ON) ? on_state_low_power : 1'b1) :
                     ((state_d == ST_SLEEP) ? sleep_state_low_power : on_state_low_power);
  wire [4:0] volt_d = hwc_active ?
                      (hw_control_voltage_choice ? sleep_state_voltage : on_state_voltage) :
                      ((state_d == ST_SLEEP) ? sleep_state_voltage : on_state_voltage);
  wire [11:0] mv_lo = MV_BASE + 12'(volt_d) * MV_STEP_LO;
  wire [11:0] mv_hi = MV_HIGH_BASE + 12'(volt_d - MV_KNEE_CODE - 5'h1) * MV_STEP_HI;
  wire [11:0] mv_d = (volt_d <= MV_KNEE_CODE) ? mv_lo : mv_hi;
  wire discharge_d = !enable_d && !output_float_on_disable;
  wire [15:0] status_set = {15'h0000, uv_rise};
  wire [15:0] status_clr = (wr_go && hit_status) ? (wdata & lane_mask) : 16'h0000;
  wire [15:0] status_d = ((irq_status_q & ~status_clr) | status_set) & IRQ_MASK;

  // ==========================================================
  // register file
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_hwc_q <= FAULT_HWC_RST;
      on_cfg_q <= ON_STATE_RST;
      sleep_cfg_q <= SLEEP_STATE_RST;
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (wr_go) begin
      if (hit_fault) fault_hwc_q <= merge(fault_hwc_q, lane_mask, wdata, FAULT_HWC_MASK);
      if (hit_on) on_cfg_q <= merge(on_cfg_q, lane_mask, wdata, STATE_CFG_MASK);
      if (hit_sleep) sleep_cfg_q <= merge(sleep_cfg_q, lane_mask, wdata, STATE_CFG_MASK);
      if (hit_enable) irq_enable_q <= merge(irq_enable_q, lane_mask, wdata, IRQ_MASK);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      wait_q <= !req_new;
      if (req_new && i_avs_read) o_avs_readdata <= {16'h0000, rd_word};
    end
  end
  assign o_avs_waitrequest = wait_q;

  // ==========================================================
  // state and outputs
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_OFF;
      irq_status_q <= 16'h0000;
      o_reg_enable <= 1'b0;
      o_reg_low_power <= 1'b0;
      o_reg_voltage <= 5'h00;
      o_target_mv <= MV_BASE;
      o_output_discharge <= 1'b1;
      o_switch_mode <= 1'b0;
      o_device_reset <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      irq_status_q <= status_d;
      o_reg_enable <= enable_d;
      o_reg_low_power <= low_power_d;
      o_reg_voltage <= volt_d;
      o_target_mv <= mv_d;
      o_output_discharge <= discharge_d;
      o_switch_mode <= switch_mode_select;
      o_device_reset <= uv_reset;
      o_irq <= |(status_d & irq_enable_q);
    end
  end

  // ==========================================================
  // assertions
  property p_uv_shutdown;
    @(posedge i_mclk) disable iff (!i_resetn)
    uv_shut |=> (state_q == ST_OFF) && !o_reg_enable;
  endproperty
  a_uv_shutdown: assert property (p_uv_shutdown) else $error("fault did not shut down");

  property p_dev_reset_cause;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_device_reset |-> $past(uv_rise) && $past(uv_action) == ACT_DEV_RESET;
  endproperty
  a_dev_reset_cause: assert property (p_dev_reset_cause) else $error("reset without cause");

  property p_irq_always;
    @(posedge i_mclk) disable iff (!i_resetn)
    uv_rise |=> irq_status_q[UV_IRQ_BIT] ##0 (o_irq == irq_enable_q[UV_IRQ_BIT]);
  endproperty
  a_irq_always: assert property (p_irq_always) else $error("fault flag not set");

  property p_hwc_off;
    @(posedge i_mclk) disable iff (!i_resetn)
    hwc_active && hw_control_mode == HWM_OFF |=> !o_reg_enable;
  endproperty
  a_hwc_off: assert property (p_hwc_off) else $error("hardware off ignored");

  property p_hwc_volt;
    @(posedge i_mclk) disable iff (!i_resetn)
    hwc_active && hw_control_voltage_choice |=> o_reg_voltage == $past(sleep_state_voltage);
  endproperty
  a_hwc_volt: assert property (p_hwc_volt) else $error("wrong hardware voltage");

  property p_discharge;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_reg_enable |-> !o_output_discharge;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while enabled");

  property p_startup;
    @(posedge i_mclk) disable iff (!i_resetn)
    startup_hit && !uv_shut |=> state_q == ST_ON;
  endproperty
  a_startup: assert property (p_startup) else $error("slot did not enable");

  property p_hw_enable;
    @(posedge i_mclk) disable iff (!i_resetn)
    on_hw && hwe_sel && state_q == ST_OFF && !uv_shut |=> state_q == ST_ON;
  endproperty
  a_hw_enable: assert property (p_hw_enable) else $error("hardware enable ignored");

  property p_sleep_disable;
    @(posedge i_mclk) disable iff (!i_resetn)
    sleep_disable && state_q == ST_ON |=> state_q == ST_OFF;
  endproperty
  a_sleep_disable: assert property (p_sleep_disable) else $error("sleep did not disable");

  property p_sleep_mode;
    @(posedge i_mclk) disable iff (!i_resetn)
    state_d == ST_SLEEP && !hwc_active |=> o_reg_low_power == $past(sleep_state_low_power);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("wrong sleep mode");

  property p_mv_low;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_reg_voltage == 5'h0C |-> o_target_mv == 12'd1600;
  endproperty
  a_mv_low: assert property (p_mv_low) else $error("knee voltage wrong");

  property p_mv_high;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_reg_voltage == 5'h1F |-> o_target_mv == 12'd3500;
  endproperty
  a_mv_high: assert property (p_mv_high) else $error("top voltage wrong");

  property p_reserved_zero;
    @(posedge i_mclk) disable iff (!i_resetn)
    !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_bus_answer;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");

  c_uv_reset: cover property (@(posedge i_mclk) disable iff (!i_resetn) uv_reset);
  c_to_sleep: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    state_q == ST_ON ##1 state_q == ST_SLEEP);
  c_hw_follow: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    on_hw && state_q == ST_ON);
  c_irq: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_irq);
endmodule : ldo_channel_control_regs

/* rtl/ldo_regs_pkg.sv */
/*
  constants for the low-noise regulator channel register bank: register
  indices, field positions, writable masks, reset values, state codes.
  assumes an avalon-mm master with byte addresses and 32-bit data.
*/
package ldo_regs_pkg;
  // ==========================================================
  // bus and register indices (byte address = index * 4)
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam logic [15:0] IDX_FAULT_HWC = 16'h407A;
  localparam logic [15:0] IDX_ON_STATE = 16'h407B;
  localparam logic [15:0] IDX_SLEEP_STATE = 16'h407C;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h4080;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h4081;
  // ==========================================================
  // field positions
  localparam int ACT_LO = 14;
  localparam int SRC_LO = 11;
  localparam int HWC_VSEL_BIT = 10;
  localparam int HWM_LO = 8;
  localparam int FLT_BIT = 7;
  localparam int SWI_BIT = 6;
  localparam int SLOT_LO = 13;
  localparam int MODE_BIT = 8;
  localparam int VOLT_LO = 0;
  localparam int UV_IRQ_BIT = 0;
  // ==========================================================
  // writable masks and reset values
  localparam logic [15:0] FAULT_HWC_MASK = 16'hDFC0;
  localparam logic [15:0] STATE_CFG_MASK = 16'hE11F;
  localparam logic [15:0] IRQ_MASK = 16'h0001;
  localparam logic [15:0] FAULT_HWC_RST = 16'h0200;
  localparam logic [15:0] ON_STATE_RST = 16'h0000;
  localparam logic [15:0] SLEEP_STATE_RST = 16'h0100;
  localparam logic [15:0] IRQ_ENABLE_RST = 16'h0001;
  // ==========================================================
  // field codes
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
  localparam logic [1:0] ACT_DEV_RESET = 2'h2;
  localparam logic [1:0] SRC_HWC1 = 2'h1;
  localparam logic [1:0] SRC_HWC2 = 2'h2;
  localparam logic [1:0] SRC_EITHER = 2'h3;
  localparam logic [1:0] HWM_OFF = 2'h1;
  localparam logic [1:0] HWM_FOLLOW_ON = 2'h3;
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  // ==========================================================
  // output voltage encoding in millivolts
  localparam logic [4:0] MV_KNEE_CODE = 5'h0C;
  localparam logic [11:0] MV_BASE = 12'd1000;
  localparam logic [11:0] MV_STEP_LO = 12'd50;
  localparam logic [11:0] MV_HIGH_BASE = 12'd1700;
  localparam logic [11:0] MV_STEP_HI = 12'd100;
  // ==========================================================
  // regulator state
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ON = 3'b010,
    ST_SLEEP = 3'b100
  } reg_state_t;
endpackage : ldo_regs_pkg

/* testbench/ldo_channel_control_regs_tb.sv */
/*
  self-checking bench for the regulator channel register bank: avalon-mm
  register access, sequencer strobes, hardware pins and the interrupt.
  assumes the package constants and the one-cycle waitrequest answer.
*/
`timescale 1ns/1ns
`define CHECK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module ldo_channel_control_regs_tb;
  import ldo_regs_pkg::*;
  // ==========================================================
  // signals
  logic i_mclk;
  logic i_resetn;
  logic [ADDR_W-1:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [DATA_W-1:0] i_avs_writedata;
  logic [DATA_W-1:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_undervoltage;
  logic i_hw_control1;
  logic i_hw_control2;
  logic i_hw_enable1;
  logic i_hw_enable2;
  logic i_seq_strobe;
  logic [2:0] i_seq_slot;
  logic i_seq_to_sleep;
  logic o_reg_enable;
  logic o_reg_low_power;
  logic [4:0] o_reg_voltage;
  logic [11:0] o_target_mv;
  logic o_output_discharge;
  logic o_switch_mode;
  logic o_device_reset;
  logic o_irq;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int rst_pulses = 0;
  // ==========================================================
  // design
  ldo_channel_control_regs dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_undervoltage(i_undervoltage),
    .i_hw_control1(i_hw_control1), .i_hw_control2(i_hw_control2),
    .i_hw_enable1(i_hw_enable1), .i_hw_enable2(i_hw_enable2), .i_seq_strobe(i_seq_strobe),
    .i_seq_slot(i_seq_slot), .i_seq_to_sleep(i_seq_to_sleep), .o_reg_enable(o_reg_enable),
    .o_reg_low_power(o_reg_low_power), .o_reg_voltage(o_reg_voltage),
    .o_target_mv(o_target_mv), .o_output_discharge(o_output_discharge),
    .o_switch_mode(o_switch_mode), .o_device_reset(o_device_reset), .o_irq(o_irq)
  );
  // ==========================================================
  // clock, timeout, pulse counter
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (o_device_reset === 1'b1) rst_pulses++;
    if (cycles == 20000) begin
      bad_count++;
      $display("ERROR timeout");
      end_sim();
    end
  end
  // ==========================================================
  // tasks
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_address <= {idx, 2'b00};
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    i_avs_writedata <= {16'h0000, wd};
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    `CHECK("waitrequest", 1'b0, o_avs_waitrequest)
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
  endtask : wr
  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [15:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 16'h0000, v);
    `CHECK(nm, {16'h0000, exp}, v)
  endtask : rdchk
  task automatic seq(input int slot, input logic slp);
    @(posedge i_mclk);
    i_seq_strobe <= 1'b1;
    i_seq_slot <= slot[2:0];
    i_seq_to_sleep <= slp;
    @(posedge i_mclk);
    i_seq_strobe <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : seq
  task automatic pins(input logic c1, input logic c2, input logic e1, input logic e2,
                      input logic uv);
    @(posedge i_mclk);
    i_hw_control1 <= c1;
    i_hw_control2 <= c2;
    i_hw_enable1 <= e1;
    i_hw_enable2 <= e2;
    i_undervoltage <= uv;
    repeat (8) @(posedge i_mclk);
  endtask : pins
  task automatic outs(input logic en, input logic lp, input logic dis);
    repeat (2) @(negedge i_mclk);
    `CHECK("enable", en, o_reg_enable)
    `CHECK("low_power", lp, o_reg_low_power)
    `CHECK("discharge", dis, o_output_discharge)
  endtask : outs
  // ==========================================================
  // tests
  logic [4:0] vcode[6] = '{5'h00, 5'h01, 5'h0C, 5'h0D, 5'h1E, 5'h1F};
  logic [11:0] vmv[6] = '{12'd1000, 12'd1050, 12'd1600, 12'd1700, 12'd3400, 12'd3500};
  logic [3:0] hwc[8] = '{4'h3, 4'h7, 4'h3, 4'h4, 4'h5, 4'h2, 4'h1, 4'h2};
  initial begin
    int c;
    int n0;
    i_resetn = 1'b0;
    {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata} = '0;
    {i_undervoltage, i_hw_control1, i_hw_control2, i_hw_enable1, i_hw_enable2} = '0;
    {i_seq_strobe, i_seq_slot, i_seq_to_sleep} = '0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rdchk("fault_hwc", IDX_FAULT_HWC, 16'h0200);
    rdchk("on_state", IDX_ON_STATE, 16'h0000);
    rdchk("sleep_state", IDX_SLEEP_STATE, 16'h0100);
    rdchk("irq_enable", IDX_IRQ_ENABLE, 16'h0001);
    outs(1'b0, 1'b0, 1'b1);
    `CHECK("target_mv", 12'd1000, o_target_mv)
    wr(IDX_FAULT_HWC, 16'hFFFF);
    rdchk("fault_hwc", IDX_FAULT_HWC, FAULT_HWC_MASK);
    `CHECK("switch", 1'b1, o_switch_mode)
    wr(IDX_FAULT_HWC, 16'h0200);
    wr(IDX_ON_STATE, 16'hFFFF);
    rdchk("on_state", IDX_ON_STATE, STATE_CFG_MASK);
    wr(IDX_SLEEP_STATE, 16'hFFFF);
    rdchk("sleep_state", IDX_SLEEP_STATE, STATE_CFG_MASK);
    wr(16'h407D, 16'hFFFF);
    rdchk("unmapped", 16'h407D, 16'h0000);
    // enable slots 1..5 and disable slots 5..1, with a wrong slot first
    for (c = 1; c <= 5; c++) begin
      wr(IDX_SLEEP_STATE, {c[2:0], 13'h0100});
      wr(IDX_ON_STATE, {c[2:0], 13'h0000});
      seq(c % 5 + 1, 1'b0);
      outs(1'b0, 1'b0, 1'b1);
      seq(c, 1'b0);
      outs(1'b1, 1'b0, 1'b0);
      seq((6 - c) % 5 + 1, 1'b1);
      outs(1'b1, 1'b0, 1'b0);
      seq(6 - c, 1'b1);
      outs(1'b0, 1'b0, 1'b1);
    end
    wr(IDX_ON_STATE, 16'h0000);
    for (c = 1; c <= 5; c++) seq(c, 1'b0);
    outs(1'b0, 1'b0, 1'b1);
    wr(IDX_FAULT_HWC, 16'h0280);
    outs(1'b0, 1'b0, 1'b0);
    wr(IDX_FAULT_HWC, 16'h0200);
    // voltage codes in the on state
    wr(IDX_ON_STATE, 16'h2000);
    seq(1, 1'b0);
    for (c = 0; c < 6; c++) begin
      wr(IDX_ON_STATE, {11'h100, vcode[c]});
      repeat (3) @(negedge i_mclk);
      `CHECK("voltage", vcode[c], o_reg_voltage)
      `CHECK("target_mv", vmv[c], o_target_mv)
    end
    wr(IDX_ON_STATE, 16'h2100);
    outs(1'b1, 1'b1, 1'b0);
    wr(IDX_ON_STATE, 16'h2000);
    // sleep transitions without disabling: codes 000, 110, 111
    for (c = 0; c < 3; c++) begin
      wr(IDX_SLEEP_STATE, {(c == 0) ? 3'h0 : 3'h5 + c[2:0], 13'h011F});
      seq((5 - 2 * c) % 5 + 1, 1'b1);
      outs(1'b1, 1'b0, 1'b0);
      seq(5 - 2 * c, 1'b1);
      outs(1'b1, 1'b1, 1'b0);
      `CHECK("sleep_mv", 12'd3500, o_target_mv)
      seq(1, 1'b0);
      outs(1'b1, 1'b0, 1'b0);
    end
    // hardware control sources, mode off, then modes and voltage choice
    for (c = 0; c < 8; c++) begin
      wr(IDX_FAULT_HWC, {3'h0, c[2:1], 11'h100});
      pins(hwc[c][2], hwc[c][1], 1'b0, 1'b0, 1'b0);
      outs(hwc[c][0], ~hwc[c][0], ~hwc[c][0]);
    end
    wr(IDX_FAULT_HWC, 16'h0800);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    outs(1'b1, 1'b1, 1'b0);
    wr(IDX_FAULT_HWC, 16'h0B00);
    outs(1'b1, 1'b0, 1'b0);
    wr(IDX_FAULT_HWC, 16'h0F00);
    repeat (3) @(negedge i_mclk);
    `CHECK("hwc_mv", 12'd3500, o_target_mv)
    wr(IDX_FAULT_HWC, 16'h0200);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // hardware enable inputs, sleep slot choice under hardware enable
    wr(IDX_SLEEP_STATE, 16'h6100);
    for (c = 0; c < 2; c++) begin
      wr(IDX_ON_STATE, {2'h3, c[0], 13'h0000});
      pins(1'b0, 1'b0, c == 0, c == 1, 1'b0);
      outs(1'b1, 1'b0, 1'b0);
      seq(2, 1'b1);
      outs(1'b1, 1'b0, 1'b0);
      seq(3, 1'b1);
      outs(1'b1, 1'b1, 1'b0);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      outs(1'b0, 1'b0, 1'b1);
    end
    // undervoltage with every error action
    wr(IDX_ON_STATE, 16'h2000);
    for (c = 0; c < 4; c++) begin
      wr(IDX_FAULT_HWC, {c[1:0], 14'h0200});
      seq(1, 1'b0);
      n0 = rst_pulses;
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      @(negedge i_mclk);
      `CHECK("irq", 1'b1, o_irq)
      if (c != 2) `CHECK("uv_enable", c != 1, o_reg_enable)
      `CHECK("reset_pulses", n0 + (c == 2), rst_pulses)
      rdchk("irq_status", IDX_IRQ_STATUS, 16'h0001);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(IDX_IRQ_STATUS, 16'h0001);
      rdchk("irq_status", IDX_IRQ_STATUS, 16'h0000);
      @(negedge i_mclk);
      `CHECK("irq", 1'b0, o_irq)
    end
    wr(IDX_IRQ_ENABLE, 16'h0000);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge i_mclk);
    `CHECK("masked_irq", 1'b0, o_irq)
    wr(IDX_IRQ_ENABLE, 16'h0001);
    repeat (2) @(negedge i_mclk);
    `CHECK("unmasked_irq", 1'b1, o_irq)
    end_sim();
  end
endmodule : ldo_channel_control_regs_tb
